// ==== lvds_output_formatter.sv ====
`timescale 1ns/10ps
`default_nettype none
// How it works
// - drive current standard at reset, register lowers it
// - word encoding offset binary, twos complement, Gray
// - power-down turns all output enables off
// - sample reaches the link hand-off 33 sample clocks after entry
// - forwarded clock phase in four 90 degree steps
// - new data on both forwarded clock edges
// - overrange flag delayed 33 cycles with sample
// - mode 0: one 14-bit word, fourteen lanes
// - mode 1: two 14-bit words interleaved
// - modes 2,3: even/odd bit pairs per lane
// - mode 4: 16-bit word over byte lanes
// - mode 5: two converters, real decimation 2-8
// - modes 6,7: four/eight converters, no noise shaping
// - output rate = sample rate/decimation, line 1000 max
// - byte modes: frame clock and status lanes
module lvds_output_formatter (
    // clocks and reset
    input  wire logic                                       SYS_CLK,
    input  wire logic                                       ARST_N,
    input  wire logic                                       LINK_CLK,
    // register port
    input  wire logic [11:0]                                REG_ADDR,
    input  wire logic                                       REG_WR,
    input  wire logic [7:0]                                 REG_WDATA,
    output var  logic [7:0]                                 REG_RDATA,
    // converter samples
    input  wire logic                                       SAMPLE_VALID,
    input  wire logic [fmt_pkg::NUM_CONV-1:0][fmt_pkg::SAMPLE_W-1:0] SAMPLE_WORDS,
    input  wire logic [fmt_pkg::NUM_CONV-1:0]               SAMPLE_OVERRANGE,
    // configuration
    input  wire logic [1:0]                                 DATA_FORMAT,
    input  wire logic [2:0]                                 DECIM_LOG2,
    input  wire logic                                       COMPLEX_OUT,
    input  wire logic                                       NSR_REQUEST,
    input  wire logic                                       VDR_REQUEST,
    input  wire logic [9:0]                                 ADC_RATE_MSPS,
    input  wire logic                                       POWER_DOWN,
    // status
    output var  logic                                       CONFIG_ERROR,
    output var  logic                                       VARIABLE_RANGE_MONITOR_ACTIVE,
    output var  logic                                       NOISE_SHAPING_REQUANTIZER_ACTIVE,
    output var  logic [9:0]                                 OUTPUT_SAMPLE_RATE,
    output var  logic [7:0]                                 DRIVE_CURRENT,
    // link
    output var  logic                                       FORWARDED_DATA_CLOCK,
    output var  logic [fmt_pkg::NUM_LANES-1:0]              PARALLEL_BIT_LANES,
    output var  logic                                       OVERRANGE_LANE,
    output var  logic                                       OUT_ENABLE
);

    ////////////////////////////////////////////////////////////////////////////////
    // functions

    function automatic logic [15:0] encode_word(input logic [15:0] w,
                                                input logic [1:0] f);
        logic [15:0] ob;
        ob = {~w[15], w[14:0]};
        case (f)
            fmt_pkg::FMT_TWOS: return w;
            fmt_pkg::FMT_GRAY: return ob ^ (ob >> 1);
            default:           return ob;
        endcase
    endfunction

    // DDR beats per sample group, which is also the line-rate factor
    function automatic logic [4:0] group_beats(input fmt_pkg::mode_type m);
        case (m)
            fmt_pkg::MODE_PAR_ONE:    return 5'h01;
            fmt_pkg::MODE_BYTE_TWO:   return 5'h04;
            fmt_pkg::MODE_BYTE_FOUR:  return 5'h08;
            fmt_pkg::MODE_BYTE_EIGHT: return 5'h10;
            default:                  return 5'h02;
        endcase
    endfunction

    function automatic logic decim_legal(input fmt_pkg::mode_type m,
                                         input logic cplx,
                                         input logic [2:0] d,
                                         input logic [9:0] rate);
        logic ok;
        ok = 1'b0;
        case (m)
            fmt_pkg::MODE_PAR_ONE, fmt_pkg::MODE_MUX_ONE, fmt_pkg::MODE_BYTE_ONE: begin
                ok = !cplx && d <= fmt_pkg::DECIM_8;
            end
            fmt_pkg::MODE_PAR_TWO, fmt_pkg::MODE_MUX_TWO: begin
                ok = cplx ? (d >= fmt_pkg::DECIM_2 && d <= fmt_pkg::DECIM_16)
                          : (d <= fmt_pkg::DECIM_8);
            end
            fmt_pkg::MODE_BYTE_TWO, fmt_pkg::MODE_BYTE_FOUR: begin
                ok = cplx ? (d >= fmt_pkg::DECIM_2 && d <= fmt_pkg::DECIM_16)
                          : (d >= fmt_pkg::DECIM_2 && d <= fmt_pkg::DECIM_8);
            end
            fmt_pkg::MODE_BYTE_EIGHT: begin
                ok = cplx && d >= fmt_pkg::DECIM_4 && d <= fmt_pkg::DECIM_16
                     && (d != fmt_pkg::DECIM_4 || rate <= fmt_pkg::EIGHT_CONV_MAX_MSPS);
            end
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    function automatic logic nsr_legal(input fmt_pkg::mode_type m, input logic [2:0] d);
        case (m)
            fmt_pkg::MODE_BYTE_TWO:                            return d == fmt_pkg::DECIM_2;
            fmt_pkg::MODE_BYTE_FOUR, fmt_pkg::MODE_BYTE_EIGHT: return 1'b0;
            default:                                           return d <= fmt_pkg::DECIM_2;
        endcase
    endfunction

    function automatic fmt_pkg::beat_type beat_word(input fmt_pkg::sample_group_type g,
                                                   input logic [3:0] b,
                                                   input logic [4:0] n);
        fmt_pkg::beat_type r;
        logic [2:0]        cv;
        r  = '0;
        cv = b[3:1];
        case (g.mode)
            fmt_pkg::MODE_PAR_ONE: begin
                r.lanes     = g.word[0][fmt_pkg::SAMPLE_W-1:fmt_pkg::WORD14_LSB];
                r.side_lane = g.over[0];
            end
            fmt_pkg::MODE_PAR_TWO: begin
                r.lanes     = g.word[b[0]][fmt_pkg::SAMPLE_W-1:fmt_pkg::WORD14_LSB];
                r.side_lane = g.over[b[0]];
            end
            fmt_pkg::MODE_MUX_ONE, fmt_pkg::MODE_MUX_TWO: begin
                for (int k = 0; k < fmt_pkg::NUM_PAIRS; k++) begin
                    r.lanes[fmt_pkg::A_PAIR_BASE+k] =
                        g.word[0][fmt_pkg::WORD14_LSB+2*k+int'(b[0])];
                    if (g.mode == fmt_pkg::MODE_MUX_TWO) begin
                        r.lanes[k] = g.word[1][fmt_pkg::WORD14_LSB+2*k+int'(b[0])];
                    end
                end
                r.side_lane = (g.mode == fmt_pkg::MODE_MUX_TWO) ? g.over[b[0]] : g.over[0];
            end
            default: begin
                r.lanes[fmt_pkg::BYTE_BASE +: 8] = b[0] ? g.word[cv][7:0]
                                                        : g.word[cv][15:8];
                r.lanes[fmt_pkg::STATUS_PIN]     = g.over[cv];
                r.side_lane = {1'b0, b} < (n >> 1);
            end
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // registers

    logic [7:0]        mode_reg;
    logic [7:0]        phase_reg;
    logic [7:0]        drive_reg;
    fmt_pkg::mode_type mode_sel;

    assign mode_sel = fmt_pkg::mode_type'(mode_reg[fmt_pkg::MODE_W-1:0]);

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            mode_reg  <= fmt_pkg::RESET_OUTPUT_MODE_SELECT;
            phase_reg <= fmt_pkg::RESET_CLOCK_OUT_PHASE;
            drive_reg <= fmt_pkg::RESET_OUTPUT_DRIVE_CURRENT;
        end else if (REG_WR) begin
            case (REG_ADDR)
                fmt_pkg::ADDR_OUTPUT_MODE_SELECT:     mode_reg  <= REG_WDATA;
                fmt_pkg::ADDR_CLOCK_OUT_PHASE_ADJUST: phase_reg <= REG_WDATA;
                fmt_pkg::ADDR_OUTPUT_DRIVE_CURRENT:   drive_reg <= REG_WDATA;
                default: ;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            REG_RDATA <= 8'h00;
        end else begin
            case (REG_ADDR)
                fmt_pkg::ADDR_OUTPUT_MODE_SELECT:     REG_RDATA <= mode_reg;
                fmt_pkg::ADDR_CLOCK_OUT_PHASE_ADJUST: REG_RDATA <= phase_reg;
                fmt_pkg::ADDR_OUTPUT_DRIVE_CURRENT:   REG_RDATA <= drive_reg;
                default:                              REG_RDATA <= 8'h00;
            endcase
        end
    end

    assign DRIVE_CURRENT = drive_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // configuration checks

    logic [9:0]  next_out_rate;
    logic [14:0] next_line_rate;
    logic        next_config_error;

    always_comb begin
        next_out_rate     = ADC_RATE_MSPS >> DECIM_LOG2;
        next_line_rate    = 15'(next_out_rate * group_beats(mode_sel));
        next_config_error = !decim_legal(mode_sel, COMPLEX_OUT, DECIM_LOG2, next_out_rate)
                            || next_line_rate > fmt_pkg::MAX_LINE_RATE_MBPS
                            || (NSR_REQUEST && !nsr_legal(mode_sel, DECIM_LOG2));
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            CONFIG_ERROR                     <= 1'b0;
            OUTPUT_SAMPLE_RATE               <= 10'h000;
            VARIABLE_RANGE_MONITOR_ACTIVE    <= 1'b0;
            NOISE_SHAPING_REQUANTIZER_ACTIVE <= 1'b0;
        end else begin
            CONFIG_ERROR                     <= next_config_error;
            OUTPUT_SAMPLE_RATE               <= next_out_rate;
            VARIABLE_RANGE_MONITOR_ACTIVE    <= VDR_REQUEST
                                                && mode_sel < fmt_pkg::MODE_BYTE_ONE;
            NOISE_SHAPING_REQUANTIZER_ACTIVE <= NSR_REQUEST
                                                && nsr_legal(mode_sel, DECIM_LOG2);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // encode and pipeline delay

    fmt_pkg::pipe_type enc_stage;
    fmt_pkg::pipe_type delayed;

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            enc_stage <= '0;
        end else begin
            enc_stage.valid <= SAMPLE_VALID;
            enc_stage.over  <= SAMPLE_OVERRANGE;
            for (int c = 0; c < fmt_pkg::NUM_CONV; c++) begin
                enc_stage.word[c] <= encode_word(SAMPLE_WORDS[c], DATA_FORMAT);
            end
        end
    end

    // one encode stage plus this line make the 33-cycle latency up to the link hand-off
    sample_delay_line #(
        .WIDTH ($bits(fmt_pkg::pipe_type)),
        .DEPTH (fmt_pkg::PIPE_DEPTH)
    ) u_delay (
        .clk    (SYS_CLK),
        .arst_n (ARST_N),
        .din    (enc_stage),
        .dout   (delayed)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // hand-off to the link domain

    fmt_pkg::sample_group_type         hold_group;
    logic                              req_toggle;
    logic                              ack_toggle;
    logic [fmt_pkg::SYNC_STAGES-1:0]   ack_sync;
    logic                              ack_seen;
    logic                              busy;

    assign busy = req_toggle != ack_seen;

    // group arriving while the link is busy is dropped; hold stays stable meanwhile
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            hold_group <= '0;
            req_toggle <= 1'b0;
        end else if (delayed.valid && !busy && !CONFIG_ERROR) begin
            hold_group.word  <= delayed.word;
            hold_group.over  <= delayed.over;
            hold_group.mode  <= mode_sel;
            hold_group.phase <= phase_reg[fmt_pkg::PHASE_W-1:0];
            req_toggle       <= ~req_toggle;
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ack_sync <= '0;
            ack_seen <= 1'b0;
        end else begin
            ack_sync <= {ack_sync[1:0], ack_toggle};
            if (ack_sync[1] == ack_sync[2]) begin
                ack_seen <= ack_sync[2];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // link domain: reset release and input synchronisers

    logic [1:0]                      link_rst;
    logic                            link_arst_n;
    logic [fmt_pkg::SYNC_STAGES-1:0] req_sync;
    logic [fmt_pkg::SYNC_STAGES-1:0] pd_sync;
    logic                            req_seen;
    logic                            pd_seen;

    always_ff @(posedge LINK_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            link_rst <= 2'h0;
        end else begin
            link_rst <= {link_rst[0], 1'b1};
        end
    end

    assign link_arst_n = link_rst[1];

    always_ff @(posedge LINK_CLK or negedge link_arst_n) begin
        if (!link_arst_n) begin
            req_sync <= '0;
            pd_sync  <= '0;
            req_seen <= 1'b0;
            pd_seen  <= 1'b0;
        end else begin
            req_sync <= {req_sync[1:0], req_toggle};
            pd_sync  <= {pd_sync[1:0], POWER_DOWN};
            if (req_sync[1] == req_sync[2]) begin
                req_seen <= req_sync[2];
            end
            if (pd_sync[1] == pd_sync[2]) begin
                pd_seen <= pd_sync[2];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // link domain: beat sequencer

    typedef enum logic [1:0] {
        IDLE = 2'b00,
        SEND = 2'b01
    } link_state_type;

    link_state_type            state;
    fmt_pkg::sample_group_type cur_group;
    logic [3:0]                beat;
    logic [1:0]                quarter;
    logic                      tick;
    logic                      pending;
    logic [4:0]                beats_now;
    logic                      last_beat;

    // each DDR beat lasts two link cycles, one half of the forwarded clock
    assign tick      = quarter[0];
    assign pending   = req_seen != ack_toggle;
    assign beats_now = group_beats(cur_group.mode);
    assign last_beat = {1'b0, beat} == beats_now - 5'h01;

    always_ff @(posedge LINK_CLK or negedge link_arst_n) begin
        if (!link_arst_n) begin
            quarter <= 2'h0;
        end else begin
            quarter <= quarter + 2'h1;
        end
    end

    always_ff @(posedge LINK_CLK or negedge link_arst_n) begin
        if (!link_arst_n) begin
            state      <= IDLE;
            cur_group  <= '0;
            beat       <= 4'h0;
            ack_toggle <= 1'b0;
        end else if (tick) begin
            case (state)
                IDLE: begin
                    if (pending) begin
                        cur_group  <= hold_group;
                        ack_toggle <= req_seen;
                        beat       <= 4'h0;
                        state      <= SEND;
                    end
                end
                SEND: begin
                    if (!last_beat) begin
                        beat <= beat + 4'h1;
                    end else if (pending) begin
                        cur_group  <= hold_group;
                        ack_toggle <= req_seen;
                        beat       <= 4'h0;
                    end else begin
                        state <= IDLE;
                    end
                end
                default: state <= IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // link domain: output lanes and forwarded clock

    fmt_pkg::beat_type next_beat;
    logic [1:0]        next_clock_pos;

    assign next_beat      = beat_word(cur_group, beat, beats_now);
    assign next_clock_pos = quarter + 2'h1 - cur_group.phase;

    always_ff @(posedge LINK_CLK or negedge link_arst_n) begin
        if (!link_arst_n) begin
            PARALLEL_BIT_LANES <= '0;
            OVERRANGE_LANE     <= 1'b0;
        end else if (tick) begin
            if (state == SEND) begin
                PARALLEL_BIT_LANES <= next_beat.lanes;
                OVERRANGE_LANE     <= next_beat.side_lane;
            end else begin
                PARALLEL_BIT_LANES <= '0;
                OVERRANGE_LANE     <= 1'b0;
            end
        end
    end

    always_ff @(posedge LINK_CLK or negedge link_arst_n) begin
        if (!link_arst_n) begin
            FORWARDED_DATA_CLOCK <= 1'b0;
        end else begin
            FORWARDED_DATA_CLOCK <= !next_clock_pos[1];
        end
    end

    always_ff @(posedge LINK_CLK or negedge link_arst_n) begin
        if (!link_arst_n) begin
            OUT_ENABLE <= 1'b0;
        end else begin
            OUT_ENABLE <= !pd_seen;
        end
    end

endmodule // lvds_output_formatter
`default_nettype wire

// ==== fmt_pkg.sv ====
`default_nettype none
package fmt_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register map
    localparam logic [11:0] ADDR_OUTPUT_MODE_SELECT     = 12'h568;
    localparam logic [11:0] ADDR_CLOCK_OUT_PHASE_ADJUST = 12'h569;
    localparam logic [11:0] ADDR_OUTPUT_DRIVE_CURRENT   = 12'h56A;
    localparam logic [7:0]  RESET_OUTPUT_MODE_SELECT    = 8'h00;
    localparam logic [7:0]  RESET_CLOCK_OUT_PHASE       = 8'h00;
    // zero is standard drive, any other value lowers the current
    localparam logic [7:0]  RESET_OUTPUT_DRIVE_CURRENT  = 8'h00;
    localparam int          MODE_W                      = 3;
    localparam int          PHASE_W                     = 2;

    ////////////////////////////////////////////////////////////////////////////////
    // sizes and timing
    localparam int          SAMPLE_W       = 16;
    localparam int          NUM_CONV       = 8;
    localparam int          NUM_LANES      = 14;
    localparam int          NUM_PAIRS      = 7;
    localparam int          WORD14_LSB     = 2;
    localparam int          A_PAIR_BASE    = 7;
    localparam int          BYTE_BASE      = 5;
    localparam int          STATUS_PIN     = 13;
    localparam int          LATENCY_CYCLES = 33;
    localparam int          PIPE_DEPTH     = LATENCY_CYCLES - 1;
    localparam int          SYNC_STAGES    = 3;
    localparam logic [14:0] MAX_LINE_RATE_MBPS  = 15'h03E8;
    localparam logic [9:0]  EIGHT_CONV_MAX_MSPS = 10'h07D;

    ////////////////////////////////////////////////////////////////////////////////
    // decimation codes, log2 of the ratio
    localparam logic [2:0] DECIM_1  = 3'h0;
    localparam logic [2:0] DECIM_2  = 3'h1;
    localparam logic [2:0] DECIM_4  = 3'h2;
    localparam logic [2:0] DECIM_8  = 3'h3;
    localparam logic [2:0] DECIM_16 = 3'h4;

    typedef enum logic [2:0] {
        MODE_PAR_ONE    = 3'h0,
        MODE_PAR_TWO    = 3'h1,
        MODE_MUX_ONE    = 3'h2,
        MODE_MUX_TWO    = 3'h3,
        MODE_BYTE_ONE   = 3'h4,
        MODE_BYTE_TWO   = 3'h5,
        MODE_BYTE_FOUR  = 3'h6,
        MODE_BYTE_EIGHT = 3'h7
    } mode_type;

    typedef enum logic [1:0] {
        FMT_OFFSET_BINARY = 2'h0,
        FMT_TWOS          = 2'h1,
        FMT_GRAY          = 2'h2
    } format_type;

    typedef struct packed {
        logic                               valid;
        logic [NUM_CONV-1:0]                over;
        logic [NUM_CONV-1:0][SAMPLE_W-1:0]  word;
    } pipe_type;

    typedef struct packed {
        logic [NUM_CONV-1:0]                over;
        logic [NUM_CONV-1:0][SAMPLE_W-1:0]  word;
        mode_type                           mode;
        logic [PHASE_W-1:0]                 phase;
    } sample_group_type;

    typedef struct packed {
        logic                 side_lane;
        logic [NUM_LANES-1:0] lanes;
    } beat_type;

endpackage
`default_nettype wire

// ==== sample_delay_line.sv ====
`timescale 1ns/10ps
`default_nettype none
module sample_delay_line #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             arst_n,
    // data
    input  wire logic [WIDTH-1:0] din,
    output var  logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] stage [DEPTH];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stage[0] <= '0;
        end else begin
            stage[0] <= din;
        end
    end

    genvar i;
    generate
        for (i = 1; i < DEPTH; i++) begin : g_stage
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    stage[i] <= '0;
                end else begin
                    stage[i] <= stage[i-1];
                end
            end
        end
    endgenerate

    assign dout = stage[DEPTH-1];

endmodule // sample_delay_line
`default_nettype wire

// ==== lvds_fmt_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
module lvds_fmt_checker (
    // clocks and reset
    input wire logic        SYS_CLK, ARST_N, LINK_CLK,
    // register port
    input wire logic [11:0] REG_ADDR,
    input wire logic        REG_WR,
    input wire logic [7:0]  REG_WDATA, REG_RDATA, DRIVE_CURRENT,
    // config and status
    input wire logic [2:0]  DECIM_LOG2,
    input wire logic [9:0]  ADC_RATE_MSPS, OUTPUT_SAMPLE_RATE,
    input wire logic        VDR_REQUEST, NSR_REQUEST, POWER_DOWN, CONFIG_ERROR,
    input wire logic        VARIABLE_RANGE_MONITOR_ACTIVE, NOISE_SHAPING_REQUANTIZER_ACTIVE,
    // link
    input wire logic [13:0] PARALLEL_BIT_LANES,
    input wire logic        OUT_ENABLE
);
    sequence s_write_then_hold;
        (REG_WR && REG_ADDR inside {12'h568, 12'h569, 12'h56A}) ##1 (!REG_WR && $stable(REG_ADDR));
    endsequence
    AST_READBACK: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        s_write_then_hold |=> REG_RDATA == $past(REG_WDATA, 2)) else $error("readback wrong");
    AST_DRIVE: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        REG_WR && REG_ADDR == fmt_pkg::ADDR_OUTPUT_DRIVE_CURRENT |=> DRIVE_CURRENT == $past(REG_WDATA))
        else $error("drive current not updated");
    AST_RATE: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        1'h1 |=> OUTPUT_SAMPLE_RATE == ($past(ADC_RATE_MSPS) >> $past(DECIM_LOG2)))
        else $error("rate wrong");
    AST_VDR: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        VARIABLE_RANGE_MONITOR_ACTIVE |-> $past(VDR_REQUEST)) else $error("monitor without request");
    AST_NSR: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        NOISE_SHAPING_REQUANTIZER_ACTIVE |-> $past(NSR_REQUEST) && !CONFIG_ERROR)
        else $error("noise shaping active illegally");
    AST_PD_OFF: assert property (@(posedge LINK_CLK) disable iff (!ARST_N)
        POWER_DOWN [*6] |-> !OUT_ENABLE) else $error("pins driven in power down");
    AST_PD_ON: assert property (@(posedge LINK_CLK) disable iff (!ARST_N)
        !POWER_DOWN [*8] |-> OUT_ENABLE) else $error("pins not driven");
    AST_BEAT: assert property (@(posedge LINK_CLK) disable iff (!ARST_N)
        $changed(PARALLEL_BIT_LANES) |=> $stable(PARALLEL_BIT_LANES)) else $error("beat too short");
endmodule // lvds_fmt_checker
bind lvds_output_formatter lvds_fmt_checker lvds_fmt_checker_i (.*);
`default_nettype wire

// ==== lvds_capture_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module lvds_capture_model (
    // link pins
    input wire logic        forwarded_data_clock, side, oe,
    input wire logic [13:0] lanes
);
    logic [14:0] cap [0:31];
    int          n = 0;
    // center capture on both clock edges; idle beats are all zero
    always @(forwarded_data_clock) begin
        if (oe && {side, lanes} != 15'h0) begin
            cap[n[4:0]] = {side, lanes};
            n = n + 1;
        end
    end
endmodule // lvds_capture_model
`default_nettype wire

// ==== lvds_output_formatter_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module lvds_output_formatter_tb_top;
    logic SYS_CLK = 1'h0, ARST_N = 1'h0, LINK_CLK = 1'h0, REG_WR = 1'h0, SAMPLE_VALID = 1'h0;
    logic COMPLEX_OUT = 1'h0, NSR_REQUEST = 1'h1, VDR_REQUEST = 1'h1, POWER_DOWN = 1'h0;
    logic [11:0] REG_ADDR = 12'h000;
    logic [7:0]  REG_WDATA = 8'h00, REG_RDATA, DRIVE_CURRENT, SAMPLE_OVERRANGE = 8'h01;
    logic [7:0][15:0] SAMPLE_WORDS = {8{16'h1234}};
    logic [1:0]  DATA_FORMAT = 2'h1;
    logic [2:0]  DECIM_LOG2 = 3'h0;
    logic [9:0]  ADC_RATE_MSPS = 10'h1F4, OUTPUT_SAMPLE_RATE;
    logic [13:0] PARALLEL_BIT_LANES;
    logic CONFIG_ERROR, VARIABLE_RANGE_MONITOR_ACTIVE, NOISE_SHAPING_REQUANTIZER_ACTIVE;
    logic FORWARDED_DATA_CLOCK, OVERRANGE_LANE, OUT_ENABLE;
    int n_errors = 0, checked = 0;
    always #10 SYS_CLK = ~SYS_CLK;
    always #80 LINK_CLK = ~LINK_CLK;
    lvds_output_formatter lvds_output_formatter_i (.*);
    lvds_capture_model lvds_capture_model_i (.forwarded_data_clock(FORWARDED_DATA_CLOCK), .side(OVERRANGE_LANE),
        .oe(OUT_ENABLE), .lanes(PARALLEL_BIT_LANES));
    task summarize;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge SYS_CLK) #1 {REG_ADDR, REG_WDATA, REG_WR} = {a, d, 1'h1};
        @(posedge SYS_CLK) #1 REG_WR = 1'h0;
    endtask
    task rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge SYS_CLK) #1 REG_ADDR = a;
        repeat (2) @(posedge SYS_CLK);
        #1 chk({8'h00, REG_RDATA}, {8'h00, e});
    endtask
    task send(input logic [2:0] m, input logic [1:0] f, input logic [14:0] e0, e1, input int nb);
        int n0, t;
        DATA_FORMAT = f;
        wr(fmt_pkg::ADDR_OUTPUT_MODE_SELECT, {5'h00, m});
        n0 = lvds_capture_model_i.n;
        @(posedge SYS_CLK) #1 SAMPLE_VALID = 1'h1;
        @(posedge SYS_CLK) #1 SAMPLE_VALID = 1'h0;
        chk({15'h0, VARIABLE_RANGE_MONITOR_ACTIVE}, {15'h0, m < 3'h4});
        t = 1;
        while (PARALLEL_BIT_LANES === 14'h0 && t < 200) begin
            @(posedge SYS_CLK) #1 t++;
        end
        chk({15'h0, t >= 33 && t < 120}, 16'h0001);
        repeat (150) @(posedge SYS_CLK);
        #1 chk(16'(lvds_capture_model_i.n - n0), 16'(nb));
        chk({1'h0, lvds_capture_model_i.cap[n0[4:0]]}, {1'h0, e0});
        if (nb > 1) chk({1'h0, lvds_capture_model_i.cap[5'(n0 + 1)]}, {1'h0, e1});
    endtask
    initial begin
        repeat (3) @(posedge LINK_CLK);
        @(posedge SYS_CLK) #1 ARST_N = 1'h1;
        rd(fmt_pkg::ADDR_OUTPUT_MODE_SELECT, 8'h00);
        rd(fmt_pkg::ADDR_CLOCK_OUT_PHASE_ADJUST, 8'h00);
        rd(fmt_pkg::ADDR_OUTPUT_DRIVE_CURRENT, 8'h00);
        wr(fmt_pkg::ADDR_OUTPUT_DRIVE_CURRENT, 8'h05);
        chk({8'h00, DRIVE_CURRENT}, 16'h0005);
        rd(fmt_pkg::ADDR_OUTPUT_DRIVE_CURRENT, 8'h05);
        wr(12'h56B, 8'hFF);
        rd(12'h56B, 8'h00);
        // 90 degree clock puts both edges mid-beat
        wr(fmt_pkg::ADDR_CLOCK_OUT_PHASE_ADJUST, 8'h01);
        rd(fmt_pkg::ADDR_CLOCK_OUT_PHASE_ADJUST, 8'h01);
        send(3'h0, 2'h1, 15'h448D, 15'h0, 1);
        send(3'h0, 2'h0, 15'h648D, 15'h0, 1);
        send(3'h0, 2'h2, 15'h76CB, 15'h0, 1);
        send(3'h2, 2'h1, 15'h5180, 15'h4500, 2);
        send(3'h1, 2'h1, 15'h448D, 15'h048D, 2);
        send(3'h3, 2'h1, 15'h51A3, 15'h050A, 2);
        send(3'h4, 2'h1, 15'h6240, 15'h2680, 2);
        wr(fmt_pkg::ADDR_OUTPUT_MODE_SELECT, 8'h05);
        repeat (3) @(posedge SYS_CLK);
        #1 chk({15'h0, CONFIG_ERROR}, 16'h0001);
        DECIM_LOG2 = 3'h2;
        repeat (3) @(posedge SYS_CLK);
        #1 chk({6'h00, OUTPUT_SAMPLE_RATE}, 16'h007D);
        chk({15'h0, NOISE_SHAPING_REQUANTIZER_ACTIVE}, 16'h0000);
        POWER_DOWN = 1'h1;
        repeat (100) @(posedge SYS_CLK);
        #1 chk({15'h0, OUT_ENABLE}, 16'h0000);
        POWER_DOWN = 1'h0;
        repeat (100) @(posedge SYS_CLK);
        #1 chk({15'h0, OUT_ENABLE}, 16'h0001);
        summarize;
    end
    initial begin
        #500000;
        n_errors++;
        summarize;
    end
endmodule // lvds_output_formatter_tb_top
`default_nettype wire
